// [pfc_top.v]
`timescale 1ns/1ps
`include "pfc_defs.vh"

// Summary of operation
// - warnings compare converted telemetry against thresholds
// - warning sets status bit, pulls host alert
// - no undercurrent warning exists
// - warnings never drop a converter enable
// - aux fault pulls low on selected OV/UV
// - aux fault released on commanded re-entry ON
// - fault lines are both driven and sensed
// - propagate map picks lines a fault pulls
// - response map picks lines that shut channel
// - line release restarts the channel
// - external low acts only after deglitch delay
// - long reset pin low resets all but thresholds
// - power good covers only mapped channels
// - share enable gates sequencing on input voltage
// - trim polarity bit selects correction sense
// - trim DAC has two full-scale settings
// - clear faults wipes status, frees alert
// - latched-off cleared by control, operation or shared input level
module pfc_top (
  input  wire        CORE_CLK,
  input  wire        RST_N,
  input  wire [3:0]  AVS_ADDRESS,
  input  wire        AVS_READ,
  input  wire        AVS_WRITE,
  input  wire [31:0] AVS_WRITEDATA,
  output reg  [31:0] AVS_READDATA,
  output reg         AVS_WAITREQUEST,
  input  wire [31:0] VOUT_CODE,
  input  wire [31:0] IOUT_CODE,
  input  wire        TELEM_VALID,
  input  wire [1:0]  OV_FAULT_IN,
  input  wire [1:0]  UV_FAULT_IN,
  input  wire        CONTROL_IN,
  input  wire        VIN_OK_IN,
  input  wire        WATCHDOG_RESET_INPUT_N,
  input  wire [1:0]  SHARED_FAULT_LINE_N_I,
  output reg  [1:0]  SHARED_FAULT_LINE_N_O,
  output reg  [1:0]  SHARED_FAULT_LINE_N_OE,
  output reg         AUXILIARY_FAULT_N_O,
  output reg         AUXILIARY_FAULT_N_OE,
  output reg         HOST_ALERT_N_O,
  output reg         HOST_ALERT_N_OE,
  output reg  [1:0]  CONVERTER_ENABLE_OUT,
  output reg  [1:0]  POWER_GOOD_OUT,
  output reg  [1:0]  DAC_POLARITY,
  output reg  [1:0]  DAC_FULL_SCALE_SEL
);

  // channel states
  localparam [1:0] ST_OFF  = 2'b00;   // converter off, idle
  localparam [1:0] ST_ON   = 2'b01;   // converter enabled
  localparam [1:0] ST_FLT  = 2'b10;   // faulted off, latched
  localparam [1:0] ST_LINE = 2'b11;   // off because of a fault line

  localparam integer DEG_CYC_I = `PFC_DEGLITCH_CYC;      // full width count
  localparam integer RST_CYC_I = `PFC_RESET_LOW_MIN_CYC;
  localparam [10:0]  DEG_CYC   = DEG_CYC_I[10:0];         // fits 11 bits
  localparam [10:0]  RST_CYC   = RST_CYC_I[10:0];

  reg  [2:0]  ctrl_q;                  // {share_en, operation on[1:0]}
  reg  [7:0]  cfg_q [0:1];             // per channel config
  reg  [3:0]  pgmap_q;                 // two map bits per good output
  reg  [31:0] th_q [0:3];              // warn thresholds
  reg  [9:0]  stat_q;                  // sticky status bits
  reg  [9:0]  stat_d;                  // next sticky status
  reg         aux_q;                   // aux fault asserted
  reg         por_q;                   // reset pin held long enough
  reg  [10:0] rcnt_q;                  // reset pin low counter
  reg         wait_q;                  // waitrequest copy
  wire [1:0]  pg_d;                    // next power good
  wire [8:0]  pin_raw;                 // raw async pins, filter order
  wire [8:0]  pin_f;                   // filtered async inputs
  wire [1:0]  ov_s;                    // synced supervisor OV
  wire [1:0]  uv_s;                    // synced supervisor UV
  wire        ctl_s;                   // synced control pin
  wire        vin_s;                   // synced input voltage good
  wire        wdi_s;                   // synced reset pin
  wire [1:0]  line_f;                  // deglitched fault lines, 1 = high
  wire [5:0]  warn;                    // {oc1,uv1,ov1,oc0,uv0,ov0}
  wire [7:0]  st_v;                    // both channel states
  wire [1:0]  on_v;                    // channel in ON
  wire [1:0]  flt_v;                   // channel faulted off
  wire [1:0]  line_off_v;              // channel held by a line
  wire [1:0]  enter_on;                // channel entering ON
  wire [1:0]  want_on;                 // channel commanded on
  wire        req;                     // bus request present
  wire        fire;                    // request completes this edge
  wire        clr_faults;              // clear-faults command
  wire [3:0]  th_idx;                  // threshold index

  assign req        = AVS_READ | AVS_WRITE;
  assign fire       = req & ~wait_q;
  assign th_idx     = AVS_ADDRESS - `PFC_REG_TH0;
  assign clr_faults = fire & AVS_WRITE &
                      (AVS_ADDRESS == `PFC_REG_CTRL) &
                      AVS_WRITEDATA[`PFC_CTRL_CLEAR];

  // async pins: ov, uv, control, vin, reset pin, two fault lines
  assign pin_raw = {SHARED_FAULT_LINE_N_I, WATCHDOG_RESET_INPUT_N, VIN_OK_IN,
                    CONTROL_IN, UV_FAULT_IN, OV_FAULT_IN};
  genvar i;
  generate
    for (i = 0; i < 9; i = i + 1) begin : g_pin
      pfc_line_filter #(
        .DEG_CYC ((i >= 7) ? DEG_CYC : 11'h000),
        .RST_VAL ((i >= 6) ? 1'b1 : 1'b0)
      ) u_filt (
        .clk     (CORE_CLK),
        .rst_n   (RST_N),
        .pin     (pin_raw[i]),
        .level_q (pin_f[i])
      );
    end
  endgenerate

  assign ov_s   = pin_f[1:0];
  assign uv_s   = pin_f[3:2];
  assign ctl_s  = pin_f[4];
  assign vin_s  = pin_f[5];
  assign wdi_s  = pin_f[6];
  assign line_f = pin_f[8:7];          // sensed level

  // per channel warnings and sequencing
  genvar c;
  generate
    for (c = 0; c < 2; c = c + 1) begin : g_ch
      reg  [1:0] st_q;                 // channel state
      reg  [1:0] st_d;                 // next channel state
      wire       hit;                  // a responding line is low
      wire       fault;                // fast supervisor fault

      pfc_warn_cmp u_warn (
        .vout  (VOUT_CODE[16*c +: 16]),
        .iout  (IOUT_CODE[16*c +: 16]),
        .ov_th (th_q[2*c][15:0]),
        .uv_th (th_q[2*c][31:16]),
        .oc_th (th_q[2*c+1][15:0]),
        .warn  (warn[3*c +: 3])
      );

      assign hit = |(cfg_q[c][`PFC_CFG_RESP_LSB +: 2] & ~line_f);
      assign fault = ov_s[c] | uv_s[c];
      // with share enabled, starts wait for the common input level
      assign want_on[c] = ctrl_q[`PFC_CTRL_OP_LSB + c] & ctl_s &
                          (~ctrl_q[`PFC_CTRL_SHARE] | vin_s);

      // next state; warnings are not an input here
      always @* begin
        st_d = st_q;
        case (st_q)
          ST_OFF: begin
            if (want_on[c] & ~hit) begin
              st_d = ST_ON;
            end
          end
          ST_ON: begin
            if (fault) begin
              st_d = ST_FLT;
            end else if (hit) begin
              st_d = ST_LINE;
            end else if (~want_on[c]) begin
              st_d = ST_OFF;
            end
          end
          ST_FLT: begin
            // latched until control, operation or, with share enabled, the input level drops
            if (~want_on[c]) begin
              st_d = ST_OFF;
            end
          end
          ST_LINE: begin
            // restart once the line is released
            if (~hit) begin
              st_d = want_on[c] ? ST_ON : ST_OFF;
            end
          end
          default: begin
            st_d = ST_OFF;
          end
        endcase
      end

      // state register, reset pin puts channel back off
      always @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
          st_q <= ST_OFF;
        end else if (por_q) begin
          st_q <= ST_OFF;
        end else begin
          st_q <= st_d;
        end
      end

      assign st_v[2*c +: 2] = st_q;
      assign on_v[c]        = (st_q == ST_ON);
      assign flt_v[c]       = (st_q == ST_FLT);
      assign line_off_v[c]  = (st_q == ST_LINE);
      assign enter_on[c]    = (st_q != ST_ON) & (st_d == ST_ON);
    end
  endgenerate

  // power good per output: all mapped channels good, none mapped is low
  genvar k;
  generate
    for (k = 0; k < 2; k = k + 1) begin : g_pg
      assign pg_d[k] = (|pgmap_q[2*k +: 2]) &
        (&(~pgmap_q[2*k +: 2] | (on_v & ~uv_s)));
    end
  endgenerate

  // sticky status: set wins over clear-faults
  always @* begin
    stat_d = clr_faults ? 10'h000 : stat_q;
    if (TELEM_VALID) begin
      stat_d[1:0] = stat_d[1:0] | {warn[3], warn[0]};
      stat_d[3:2] = stat_d[3:2] | {warn[4], warn[1]};
      stat_d[5:4] = stat_d[5:4] | {warn[5], warn[2]};
    end
    stat_d[7:6] = stat_d[7:6] | ov_s;
    stat_d[9:8] = stat_d[9:8] | uv_s;
  end

  // reset pin low timer; only a long enough low acts
  always @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      rcnt_q <= 11'h000;
      por_q  <= 1'b0;
    end else if (wdi_s) begin
      rcnt_q <= 11'h000;
      por_q  <= 1'b0;
    end else if (rcnt_q == RST_CYC) begin
      por_q  <= 1'b1;
    end else begin
      rcnt_q <= rcnt_q + 11'h001;
    end
  end

  // bus slave: one wait cycle, write at the fire edge, read data loaded the edge before
  always @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      wait_q          <= 1'b1;
      AVS_WAITREQUEST <= 1'b1;
      AVS_READDATA    <= 32'h00000000;
    end else begin
      wait_q          <= ~(req & wait_q);
      AVS_WAITREQUEST <= ~(req & wait_q);
      if (req & wait_q & AVS_READ) begin
        case (AVS_ADDRESS)
          `PFC_REG_CTRL:   AVS_READDATA <= {29'h0, ctrl_q};
          `PFC_REG_STATUS: AVS_READDATA <= {15'h0, aux_q, line_f,
                                            line_off_v, flt_v, stat_q};
          `PFC_REG_CFG0:   AVS_READDATA <= {24'h0, cfg_q[0]};
          `PFC_REG_CFG1:   AVS_READDATA <= {24'h0, cfg_q[1]};
          `PFC_REG_PGMAP:  AVS_READDATA <= {28'h0, pgmap_q};
          4'h6, 4'h7, 4'h8, 4'h9: AVS_READDATA <= th_q[th_idx[1:0]];
          default:         AVS_READDATA <= 32'h00000000;  // unmapped
        endcase
      end
    end
  end

  // software registers; the reset pin clears all but the thresholds
  always @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      ctrl_q   <= `PFC_CTRL_RST;
      cfg_q[0] <= `PFC_CFG_RST;
      cfg_q[1] <= `PFC_CFG_RST;
      pgmap_q  <= `PFC_PGMAP_RST;
      th_q[0]  <= `PFC_TH_V_RST;
      th_q[1]  <= `PFC_TH_I_RST;
      th_q[2]  <= `PFC_TH_V_RST;
      th_q[3]  <= `PFC_TH_I_RST;
    end else if (por_q) begin
      ctrl_q   <= `PFC_CTRL_RST;
      cfg_q[0] <= `PFC_CFG_RST;
      cfg_q[1] <= `PFC_CFG_RST;
      pgmap_q  <= `PFC_PGMAP_RST;
    end else if (fire & AVS_WRITE) begin
      case (AVS_ADDRESS)
        `PFC_REG_CTRL:  ctrl_q   <= AVS_WRITEDATA[2:0];
        `PFC_REG_CFG0:  cfg_q[0] <= AVS_WRITEDATA[7:0];
        `PFC_REG_CFG1:  cfg_q[1] <= AVS_WRITEDATA[7:0];
        `PFC_REG_PGMAP: pgmap_q  <= AVS_WRITEDATA[3:0];
        4'h6, 4'h7, 4'h8, 4'h9: th_q[th_idx[1:0]] <= AVS_WRITEDATA;
        default: ;                     // read-only or unmapped
      endcase
    end
  end

  // status, aux fault and pin drivers
  always @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      stat_q                 <= 10'h000;
      aux_q                  <= 1'b0;
      SHARED_FAULT_LINE_N_O  <= 2'b00;
      SHARED_FAULT_LINE_N_OE <= 2'b00;
      AUXILIARY_FAULT_N_O    <= 1'b0;
      AUXILIARY_FAULT_N_OE   <= 1'b0;
      HOST_ALERT_N_O         <= 1'b0;
      HOST_ALERT_N_OE        <= 1'b0;
      CONVERTER_ENABLE_OUT   <= 2'b00;
      POWER_GOOD_OUT         <= 2'b00;
      DAC_POLARITY           <= 2'b00;
      DAC_FULL_SCALE_SEL     <= 2'b00;
    end else begin
      stat_q <= por_q ? 10'h000 : stat_d;
      // set beats release so a fresh fault is never dropped
      if ((|(ov_s & {cfg_q[1][`PFC_CFG_AUX_OV], cfg_q[0][`PFC_CFG_AUX_OV]}))
          | (|(uv_s & {cfg_q[1][`PFC_CFG_AUX_UV],
                       cfg_q[0][`PFC_CFG_AUX_UV]}))) begin
        aux_q <= 1'b1;
      end else if (por_q | (|enter_on)) begin
        aux_q <= 1'b0;
      end
      // open drain: level stays low, only the enable moves
      SHARED_FAULT_LINE_N_O  <= 2'b00;
      AUXILIARY_FAULT_N_O    <= 1'b0;
      HOST_ALERT_N_O         <= 1'b0;
      SHARED_FAULT_LINE_N_OE <=
        ({2{flt_v[0]}} & cfg_q[0][`PFC_CFG_PROP_LSB +: 2]) |
        ({2{flt_v[1]}} & cfg_q[1][`PFC_CFG_PROP_LSB +: 2]);
      AUXILIARY_FAULT_N_OE   <= aux_q;
      HOST_ALERT_N_OE        <= |stat_q;
      CONVERTER_ENABLE_OUT   <= on_v;
      POWER_GOOD_OUT         <= pg_d;
      DAC_POLARITY           <= {cfg_q[1][`PFC_CFG_DAC_POL],
                                 cfg_q[0][`PFC_CFG_DAC_POL]};
      DAC_FULL_SCALE_SEL     <= {cfg_q[1][`PFC_CFG_DAC_FS],
                                 cfg_q[0][`PFC_CFG_DAC_FS]};
    end
  end

endmodule // pfc_top

// [pfc_defs.vh]
`ifndef PFC_DEFS_VH
`define PFC_DEFS_VH

// clock period of CORE_CLK
`define PFC_CLK_PERIOD_NS   10
// shared fault line deglitch, least time, rounded up
`define PFC_DEGLITCH_NS     10000
`define PFC_DEGLITCH_CYC    ((`PFC_DEGLITCH_NS + `PFC_CLK_PERIOD_NS - 1) / `PFC_CLK_PERIOD_NS)
// least low time on the watchdog/reset pin, rounded up
`define PFC_RESET_LOW_MIN_NS  1000
`define PFC_RESET_LOW_MIN_CYC ((`PFC_RESET_LOW_MIN_NS + `PFC_CLK_PERIOD_NS - 1) / `PFC_CLK_PERIOD_NS)
`define PFC_CNT_W           11

// register word indexes
`define PFC_REG_CTRL        4'h0
`define PFC_REG_STATUS      4'h1
`define PFC_REG_CFG0        4'h2
`define PFC_REG_CFG1        4'h3
`define PFC_REG_PGMAP       4'h4
`define PFC_REG_TH0         4'h6
`define PFC_REG_TH_LAST     4'h9

// control register fields
`define PFC_CTRL_OP_LSB     0
`define PFC_CTRL_SHARE      2
`define PFC_CTRL_CLEAR      8

// channel config fields
`define PFC_CFG_PROP_LSB    0
`define PFC_CFG_RESP_LSB    2
`define PFC_CFG_AUX_OV      4
`define PFC_CFG_AUX_UV      5
`define PFC_CFG_DAC_POL     6
`define PFC_CFG_DAC_FS      7

// reset values
`define PFC_CTRL_RST        3'h0
`define PFC_CFG_RST         8'h00
`define PFC_PGMAP_RST       4'h0
`define PFC_TH_V_RST        32'h0000FFFF
`define PFC_TH_I_RST        32'h0000FFFF

`endif

// [pfc_line_filter.v]
`timescale 1ns/1ps
`include "pfc_defs.vh"

module pfc_line_filter #(
  parameter [10:0] DEG_CYC = 11'h000,  // zero: no deglitch
  parameter [0:0]  RST_VAL = 1'b1      // idle level of the pin
) (
  input  wire clk,
  input  wire rst_n,
  input  wire pin,
  output reg  level_q
);

  reg        s1_q;                     // first stage, only s2 reads it
  reg        s2_q;                     // second stage
  reg        s3_q;                     // third stage
  reg        agree_q;                  // value once s2 and s3 agree
  reg [10:0] cnt_q;                    // low persistence counter

  // three flops, a change counts only when two stages agree
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_q    <= RST_VAL;
      s2_q    <= RST_VAL;
      s3_q    <= RST_VAL;
      agree_q <= RST_VAL;
    end else begin
      s1_q <= pin;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q) begin
        agree_q <= s2_q;
      end
    end
  end

  // low must persist for the whole delay; any high restarts it
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q   <= 11'h000;
      level_q <= RST_VAL;
    end else if (DEG_CYC == 11'h000) begin
      level_q <= agree_q;
    end else if (agree_q) begin
      cnt_q   <= 11'h000;
      level_q <= 1'b1;
    end else if (cnt_q == DEG_CYC) begin
      level_q <= 1'b0;
    end else begin
      cnt_q <= cnt_q + 11'h001;
    end
  end

endmodule // pfc_line_filter

// [pfc_warn_cmp.v]
`timescale 1ns/1ps

module pfc_warn_cmp (
  input  wire [15:0] vout,             // converted output voltage
  input  wire [15:0] iout,             // converted output current
  input  wire [15:0] ov_th,            // overvoltage warn threshold
  input  wire [15:0] uv_th,            // undervoltage warn threshold
  input  wire [15:0] oc_th,            // overcurrent warn threshold
  output wire [2:0]  warn              // {oc, uv, ov}
);

  // telemetry compares, not the fast supervisor inputs
  assign warn[0] = (vout > ov_th);
  assign warn[1] = (vout < uv_th);
  // current is only checked upward, no undercurrent warning
  assign warn[2] = (iout > oc_th);

endmodule // pfc_warn_cmp

// [pfc_chk_asserts.sv]
`timescale 1ns/1ps

// watches the top ports only
module pfc_chk (
  input wire logic        CORE_CLK,
  input wire logic        RST_N,
  input wire logic [3:0]  AVS_ADDRESS,
  input wire logic        AVS_READ,
  input wire logic        AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  input wire logic [31:0] AVS_READDATA,
  input wire logic        AVS_WAITREQUEST,
  input wire logic        TELEM_VALID,
  input wire logic [1:0]  OV_FAULT_IN,
  input wire logic [1:0]  UV_FAULT_IN,
  input wire logic        CONTROL_IN,
  input wire logic [1:0]  SHARED_FAULT_LINE_N_O,
  input wire logic [1:0]  SHARED_FAULT_LINE_N_OE,
  input wire logic        AUXILIARY_FAULT_N_O,
  input wire logic        AUXILIARY_FAULT_N_OE,
  input wire logic        HOST_ALERT_N_O,
  input wire logic        HOST_ALERT_N_OE,
  input wire logic [1:0]  CONVERTER_ENABLE_OUT,
  input wire logic [1:0]  POWER_GOOD_OUT
);
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RST_N);

  // bus access steps
  sequence req_start;
    $rose(AVS_READ || AVS_WRITE);
  endsequence
  sequence one_wait;
    AVS_WAITREQUEST ##1 !AVS_WAITREQUEST;
  endsequence
  // clear-faults write accepted, no new set pending
  sequence clear_taken;
    AVS_WRITE && !AVS_WAITREQUEST && AVS_ADDRESS == 4'h0 &&
      AVS_WRITEDATA[8] && OV_FAULT_IN == 2'h0 &&
      UV_FAULT_IN == 2'h0 && !TELEM_VALID;
  endsequence

  wait_cycle_a: assert property (req_start |-> one_wait)
    else $error("bus answer not after one wait cycle");
  wait_short_a: assert property (!AVS_WAITREQUEST |=> AVS_WAITREQUEST)
    else $error("waitrequest low longer than one cycle");
  unmapped_zero_a: assert property (AVS_READ && !AVS_WAITREQUEST &&
    (AVS_ADDRESS == 4'h5 || AVS_ADDRESS > 4'h9) |-> AVS_READDATA == 32'h0)
    else $error("unmapped read not zero");
  drain_only_a: assert property (SHARED_FAULT_LINE_N_O == 2'h0 &&
    !AUXILIARY_FAULT_N_O && !HOST_ALERT_N_O)
    else $error("open-drain pin driven high");
  good_needs_on_a: assert property (POWER_GOOD_OUT[0] |->
    (CONVERTER_ENABLE_OUT | $past(CONVERTER_ENABLE_OUT)) != 2'h0)
    else $error("power good with no channel on");
  line_pull_a: assert property ($rose(SHARED_FAULT_LINE_N_OE != 2'h0) |->
    ##[0:1] CONVERTER_ENABLE_OUT != 2'h3)
    else $error("fault line pulled with both channels on");
  clear_alert_a: assert property (clear_taken |->
    ##[1:2] !HOST_ALERT_N_OE)
    else $error("alert kept after clear faults");
  aux_free_a: assert property ($fell(AUXILIARY_FAULT_N_OE) |->
    ##[0:1] CONVERTER_ENABLE_OUT != 2'h0)
    else $error("aux fault released without channel on");
  on_needs_ctrl_a: assert property ($rose(CONVERTER_ENABLE_OUT[0]) |->
    $past(CONTROL_IN, 3))
    else $error("channel on without control input");
endmodule // pfc_chk

// [pfc_peer.sv]
`timescale 1ns/1ps

// other managers and a pull-up on the wired lines
module pfc_peer (
  input  wire logic       clk,
  input  wire logic [1:0] dut_oe,
  input  wire logic       aux_oe,
  input  wire logic       alert_oe,
  output wire logic [1:0] line_n,
  output wire logic       aux_n,
  output wire logic       alert_n
);
  logic [1:0] pull_q = 2'h0;    // external pull requests

  // wired-AND: any party pulling wins, else pull-up
  assign line_n  = ~(dut_oe | pull_q);
  assign aux_n   = ~aux_oe;
  assign alert_n = ~alert_oe;

  // hold one line low for n cycles, then let go
  task automatic drive_low(input int idx, input int n);
    @(posedge clk);
    pull_q[idx] <= 1'b1;
    repeat (n) @(posedge clk);
    pull_q[idx] <= 1'b0;
  endtask
endmodule // pfc_peer

// [tb_top.sv]
`timescale 1ns/1ps
`include "pfc_defs.vh"

module tb_top;
  logic        clk = 1'b0;      // core clock
  logic        rst_n = 1'b0;    // bench reset
  logic [3:0]  av_a;            // bus address
  logic        av_r;            // bus read
  logic        av_w;            // bus write
  logic [31:0] av_wd;           // bus write data
  logic [31:0] rd;              // last read value
  logic [31:0] vout;            // voltage readings
  logic [31:0] iout;            // current readings
  logic        tv;              // telemetry strobe
  logic [1:0]  ov;              // overvoltage faults
  logic [1:0]  uv;              // undervoltage faults
  logic        ctl;             // control pin
  logic        vin;             // input level good pin
  logic        wdi_n;           // reset pin, active low
  wire  [31:0] av_rd;
  wire         wreq;
  wire  [1:0]  fl_o, fl_oe, fl_n, en, pg, pol, fs;
  wire         aux_o, aux_oe, al_o, al_oe, aux_n, al_n;
  int          fails = 0;
  int          checked = 0;
  int          cyc = 0;
  // warning cases: threshold word, value, expected status bit
  logic [3:0]  wa [3] = '{`PFC_REG_TH0, `PFC_REG_TH0, 4'h7};
  logic [31:0] wv [3] = '{32'h00000100, 32'h0300FFFF, 32'h00000100};
  logic [31:0] ws [3] = '{32'h00000001, 32'h00000004, 32'h00000010};

  always #5 clk = ~clk;

  pfc_top dut (
    .CORE_CLK(clk), .RST_N(rst_n), .AVS_ADDRESS(av_a),
    .AVS_READ(av_r), .AVS_WRITE(av_w), .AVS_WRITEDATA(av_wd),
    .AVS_READDATA(av_rd), .AVS_WAITREQUEST(wreq),
    .VOUT_CODE(vout), .IOUT_CODE(iout), .TELEM_VALID(tv),
    .OV_FAULT_IN(ov), .UV_FAULT_IN(uv), .CONTROL_IN(ctl),
    .VIN_OK_IN(vin), .WATCHDOG_RESET_INPUT_N(wdi_n),
    .SHARED_FAULT_LINE_N_I(fl_n), .SHARED_FAULT_LINE_N_O(fl_o),
    .SHARED_FAULT_LINE_N_OE(fl_oe), .AUXILIARY_FAULT_N_O(aux_o),
    .AUXILIARY_FAULT_N_OE(aux_oe), .HOST_ALERT_N_O(al_o),
    .HOST_ALERT_N_OE(al_oe), .CONVERTER_ENABLE_OUT(en),
    .POWER_GOOD_OUT(pg), .DAC_POLARITY(pol), .DAC_FULL_SCALE_SEL(fs));

  pfc_peer u_peer (
    .clk(clk), .dut_oe(fl_oe), .aux_oe(aux_oe), .alert_oe(al_oe),
    .line_n(fl_n), .aux_n(aux_n), .alert_n(al_n));

  // one comparison, reported at once
  task automatic chk(input [31:0] got, input [31:0] exp);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // write held until waitrequest sampled low
  task automatic bus_wr(input [3:0] a, input [31:0] d);
    @(posedge clk);
    av_a <= a; av_wd <= d; av_w <= 1'b1;
    do @(posedge clk); while (wreq !== 1'b0);
    av_w <= 1'b0;
  endtask

  // read data taken at the accepting edge
  task automatic bus_rd(input [3:0] a);
    @(posedge clk);
    av_a <= a; av_r <= 1'b1;
    do @(posedge clk); while (wreq !== 1'b0);
    rd = av_rd;
    av_r <= 1'b0;
  endtask

  // bounded wait for channel 0 enable level
  task automatic wait_en(input logic v, input int n);
    for (int i = 0; i < n && en[0] !== v; i++) @(posedge clk);
    chk(32'(en[0]), 32'(v));
  endtask

  task automatic finish_test;
    $display("checks %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // hang guard, well above the expected run
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fails++;
      finish_test;
    end
  end

  initial begin
    av_a = 4'h0; av_r = 1'b0; av_w = 1'b0; av_wd = 32'h0;
    vout = 32'h00000200; iout = 32'h00000200; tv = 1'b0;
    ov = 2'h0; uv = 2'h0; ctl = 1'b0; vin = 1'b1; wdi_n = 1'b1;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    // reset values and an unmapped word
    bus_rd(`PFC_REG_CTRL); chk(rd, 32'h0);
    bus_rd(`PFC_REG_TH0); chk(rd, 32'h0000FFFF);
    bus_rd(4'hA); chk(rd, 32'h0);
    // channel 0 up, mapped to good output 0
    bus_wr(`PFC_REG_PGMAP, 32'h1);
    ctl <= 1'b1;
    bus_wr(`PFC_REG_CTRL, 32'h1);
    wait_en(1'b1, 30);
    repeat (3) @(posedge clk);
    chk(32'(pg), 32'h1);
    // each warning kind: sets status, alert, keeps enable
    for (int k = 0; k < 3; k++) begin
      bus_wr(wa[k], wv[k]);
      @(posedge clk) tv <= 1'b1;
      @(posedge clk) tv <= 1'b0;
      repeat (3) @(posedge clk);
      bus_rd(`PFC_REG_STATUS);
      chk(rd & 32'h3FF, ws[k]);
      chk(32'(al_n), 32'h0);
      chk(32'(en[0]), 32'h1);
      bus_wr(`PFC_REG_CTRL, 32'h101);
      repeat (3) @(posedge clk);
      bus_rd(`PFC_REG_STATUS); chk(rd & 32'h3FF, 32'h0);
      chk(32'(al_n), 32'h1);
      bus_wr(wa[k], 32'h0000FFFF);
    end
    // overvoltage fault: aux pin, line 0, latched off
    bus_wr(`PFC_REG_CFG0, 32'h11);
    ov <= 2'h1;
    repeat (3) @(posedge clk);
    ov <= 2'h0;
    wait_en(1'b0, 30);
    repeat (2) @(posedge clk);
    chk(32'(aux_n), 32'h0);
    chk(32'(fl_oe), 32'h1);
    chk(32'(fl_n), 32'h2);
    bus_rd(`PFC_REG_STATUS); chk(rd & 32'h40, 32'h40);
    repeat (50) @(posedge clk);
    chk(32'(en[0]), 32'h0);
    bus_wr(`PFC_REG_CTRL, 32'h0);
    bus_wr(`PFC_REG_CTRL, 32'h1);
    wait_en(1'b1, 30);
    chk(32'(aux_n), 32'h1);
    chk(32'(fl_oe), 32'h0);
    bus_wr(`PFC_REG_CTRL, 32'h101);
    // control pin off then on
    ctl <= 1'b0;
    wait_en(1'b0, 30);
    ctl <= 1'b1;
    wait_en(1'b1, 30);
    // share enabled: start waits for the input level
    vin <= 1'b0;
    bus_wr(`PFC_REG_CTRL, 32'h0);
    bus_wr(`PFC_REG_CTRL, 32'h5);
    repeat (20) @(posedge clk);
    chk(32'(en[0]), 32'h0);
    vin <= 1'b1;
    wait_en(1'b1, 30);
    // respond to line 0, trim bits set, then polarity alone
    bus_wr(`PFC_REG_CFG0, 32'hC4);
    repeat (2) @(posedge clk);
    chk(32'({pol[0], fs[0]}), 32'h3);
    bus_wr(`PFC_REG_CFG0, 32'h44);
    repeat (2) @(posedge clk);
    chk(32'({pol[0], fs[0]}), 32'h2);
    // two short lows: filter must restart
    u_peer.drive_low(0, 500);
    repeat (5) @(posedge clk);
    u_peer.drive_low(0, 700);
    repeat (10) @(posedge clk);
    chk(32'(en[0]), 32'h1);
    // long low: off only after the deglitch
    fork
      u_peer.drive_low(0, 1060);
      begin
        repeat (950) @(posedge clk);
        chk(32'(en[0]), 32'h1);
      end
    join
    chk(32'(en[0]), 32'h0);
    wait_en(1'b1, 40);
    // short low on the reset pin is ignored
    wdi_n <= 1'b0;
    repeat (50) @(posedge clk);
    wdi_n <= 1'b1;
    repeat (10) @(posedge clk);
    chk(32'(en[0]), 32'h1);
    // held past the least low time: power-on reset state
    wdi_n <= 1'b0;
    repeat (`PFC_RESET_LOW_MIN_CYC + 20) @(posedge clk);
    chk(32'(en[0]), 32'h0);
    wdi_n <= 1'b1;
    repeat (10) @(posedge clk);
    bus_rd(`PFC_REG_CTRL); chk(rd, 32'h0);
    bus_rd(`PFC_REG_CFG0); chk(rd, 32'h0);
    finish_test;
  end
endmodule // tb_top

bind pfc_top pfc_chk u_chk (
  .CORE_CLK, .RST_N, .AVS_ADDRESS, .AVS_READ, .AVS_WRITE,
  .AVS_WRITEDATA, .AVS_READDATA, .AVS_WAITREQUEST, .TELEM_VALID,
  .OV_FAULT_IN, .UV_FAULT_IN, .CONTROL_IN, .SHARED_FAULT_LINE_N_O,
  .SHARED_FAULT_LINE_N_OE, .AUXILIARY_FAULT_N_O, .AUXILIARY_FAULT_N_OE,
  .HOST_ALERT_N_O, .HOST_ALERT_N_OE, .CONVERTER_ENABLE_OUT,
  .POWER_GOOD_OUT);
